// ### vc12_adapt_pkg.sv
// constants shared by the byte-synchronous vc-12 adaptation
package vc12_adapt_pkg;
    localparam int SYS_CLK_KHZ = 50000;
    localparam int TRIB_BYTE_KHZ = 248;
    localparam logic [15:0] SYS_CLK_KHZ_W = 16'hc350;
    localparam logic [15:0] TRIB_BYTE_KHZ_W = 16'h00f8;
    localparam logic [7:0] MULT_NUM = 8'h23;
    localparam logic [7:0] MULT_DEN = 8'h1f;
    localparam logic [5:0] ROW_BYTES = 6'h23;
    localparam logic [1:0] ROWS_LAST = 2'h3;
    localparam logic [5:0] POS_POH = 6'h00;
    localparam logic [5:0] POS_FIRST_TS = 6'h02;
    localparam logic [5:0] POS_LAST_TS = 6'h20;
    localparam logic [4:0] TS_LAST = 5'h1e;
    localparam int LABEL_MSB = 3;
    localparam int LABEL_LSB = 1;
    localparam logic [2:0] LABEL_BYTE_SYNC = 3'h4;
    localparam logic [2:0] LABEL_PERSIST = 3'h5;
    localparam logic [3:0] SLOT_GAP = 4'h8;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] STUFF_BYTE = 8'h00;
    localparam int AIS_TIME_US = 250;
    localparam int AIS_LIMIT_CYC = AIS_TIME_US * (SYS_CLK_KHZ / 1000);
    typedef enum logic [1:0] {HUNT = 2'b01, RUN = 2'b10} align_t;
endpackage

// ### vc12_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module vc12_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // word in
    output logic out_valid, // word available
    input wire logic out_ready, // drain takes the word
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_ff != DEPTH_W);
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                mem_ff[wr_ff] <= in_data;
                wr_ff <= bump(wr_ff);
            end
            if (pop) begin
                rd_ff <= bump(rd_ff);
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // vc12_fifo

// ### vc12_byte_sync_adapt.sv
// byte-synchronous 1984 kbit/s to vc-12 adaptation, source and sink
`timescale 1ns/1ps
module vc12_byte_sync_adapt
    import vc12_adapt_pkg::*;
#(
    parameter int SRC_DEPTH = 4,
    parameter int SNK_DEPTH = 4
) (
    input wire logic sys_clk, // system clock, 50 MHz
    input wire logic reset, // synchronous, active high
    input wire logic tributary_clock, // tributary byte clock
    input wire logic [7:0] tributary_data, // tributary byte
    input wire logic tributary_byte_valid, // byte present this edge
    input wire logic tributary_frame_start, // byte is TS1
    input wire logic server_fail_in, // server signal fail, async
    input wire logic src_function_active, // source activation
    output logic [7:0] container_data, // container byte
    output logic container_clock, // toggles once per byte
    output logic container_frame_start, // byte is V5
    input wire logic [7:0] rx_container_data, // received container byte
    input wire logic rx_container_clock, // toggles once per byte
    input wire logic rx_container_frame_start, // received byte is V5
    input wire logic trail_signal_fail_in, // trail signal fail, async
    input wire logic snk_function_active, // sink activation
    output logic [7:0] tributary_out_data, // recovered byte
    output logic tributary_out_clock, // toggles once per byte
    output logic tributary_out_frame_start, // recovered byte is TS1
    output logic signal_fail_action, // signal fail toward client
    output logic label_mismatch_report, // mismatch to management
    output logic [2:0] accepted_label // accepted label
);
    // ---------------- tributary domain ----------------
    logic [1:0] trib_rst_ff;
    logic trib_tgl_ff;
    logic [8:0] trib_word_ff;
    always_ff @(posedge tributary_clock) begin
        trib_rst_ff <= {trib_rst_ff[0], reset};
    end
    // word is held for a whole byte period, far longer than the toggle sync
    always_ff @(posedge tributary_clock) begin
        if (trib_rst_ff[1]) begin
            trib_tgl_ff <= 1'b0;
            trib_word_ff <= '0;
        end else if (tributary_byte_valid) begin
            trib_tgl_ff <= ~trib_tgl_ff;
            trib_word_ff <= {tributary_frame_start, tributary_data};
        end
    end

    // ---------------- pin synchronisers ----------------
    logic [2:0] tgl_s_ff;
    logic [2:0] ssf_s_ff;
    logic [2:0] tsf_s_ff;
    logic [2:0] rck_s_ff;
    logic [2:0] rfs_s_ff;
    logic [7:0] rd1_ff;
    logic [7:0] rd2_ff;
    logic [7:0] rd3_ff;
    logic tgl_lvl_ff;
    logic ssf_lvl_ff;
    logic tsf_lvl_ff;
    logic rck_lvl_ff;
    always_ff @(posedge sys_clk) begin
        tgl_s_ff <= {tgl_s_ff[1:0], trib_tgl_ff};
        ssf_s_ff <= {ssf_s_ff[1:0], server_fail_in};
        tsf_s_ff <= {tsf_s_ff[1:0], trail_signal_fail_in};
        rck_s_ff <= {rck_s_ff[1:0], rx_container_clock};
        rfs_s_ff <= {rfs_s_ff[1:0], rx_container_frame_start};
        rd1_ff <= rx_container_data;
        rd2_ff <= rd1_ff;
        rd3_ff <= rd2_ff;
    end
    wire tgl_ok = (tgl_s_ff[1] == tgl_s_ff[2]);
    wire rck_ok = (rck_s_ff[1] == rck_s_ff[2]);
    wire trib_evt = tgl_ok && (tgl_s_ff[2] != tgl_lvl_ff);
    wire rx_evt = rck_ok && (rck_s_ff[2] != rck_lvl_ff);
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tgl_lvl_ff <= 1'b0;
            ssf_lvl_ff <= 1'b0;
            tsf_lvl_ff <= 1'b0;
            rck_lvl_ff <= 1'b0;
        end else begin
            if (tgl_ok) tgl_lvl_ff <= tgl_s_ff[2];
            if (ssf_s_ff[1] == ssf_s_ff[2]) ssf_lvl_ff <= ssf_s_ff[2];
            if (tsf_s_ff[1] == tsf_s_ff[2]) tsf_lvl_ff <= tsf_s_ff[2];
            if (rck_ok) rck_lvl_ff <= rck_s_ff[2];
        end
    end

    // ---------------- source: buffer ----------------
    logic src_in_ready;
    logic src_out_valid;
    logic src_pop;
    logic [8:0] src_head;
    vc12_fifo #(.WIDTH(9), .DEPTH(SRC_DEPTH)) u_src_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(trib_evt),
        .in_ready(src_in_ready),
        .in_data(trib_word_ff),
        .out_valid(src_out_valid),
        .out_ready(src_pop),
        .out_data(src_head)
    );
    // a byte refused by a full buffer earns no credit, so rate lock holds
    wire trib_taken = trib_evt && src_in_ready;

    // ---------------- source: rate and framing ----------------
    align_t src_st_ff;
    align_t nxt_src_st;
    logic [7:0] credit_ff;
    logic [3:0] gap_ff;
    logic [5:0] spos_ff;
    logic [1:0] srow_ff;
    wire credit_ok = (credit_ff >= MULT_DEN);
    wire slot = (src_st_ff == RUN) && credit_ok && (gap_ff == '0);
    wire s_payload = (spos_ff >= POS_FIRST_TS) && (spos_ff <= POS_LAST_TS);
    wire s_v5 = (spos_ff == POS_POH) && (srow_ff == '0);
    wire s_last = (spos_ff == ROW_BYTES - 6'h01);
    wire hunt_drop = (src_st_ff == HUNT) && src_out_valid && !src_head[8];
    wire hunt_lock = (src_st_ff == HUNT) && src_out_valid && src_head[8];
    assign src_pop = hunt_drop || (slot && s_payload && src_out_valid);
    wire [7:0] credit_add = trib_taken ? MULT_NUM : 8'h00;
    wire [7:0] credit_sub = slot ? MULT_DEN : 8'h00;
    wire [7:0] v5_byte = {4'h0, LABEL_BYTE_SYNC, 1'b0};
    wire [7:0] pay_byte = (ssf_lvl_ff || !src_out_valid) ? ALL_ONES : src_head[7:0];
    wire [7:0] poh_byte = s_v5 ? v5_byte : 8'h00;
    wire [7:0] slot_byte = s_payload ? pay_byte : ((spos_ff == POS_POH) ? poh_byte : STUFF_BYTE);
    always_comb begin
        nxt_src_st = src_st_ff;
        case (src_st_ff)
            HUNT: if (hunt_lock) nxt_src_st = RUN;
            RUN: if (!src_function_active) nxt_src_st = HUNT;
            default: nxt_src_st = HUNT;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            src_st_ff <= HUNT;
            credit_ff <= '0;
            gap_ff <= '0;
        end else begin
            src_st_ff <= nxt_src_st;
            credit_ff <= (src_st_ff == HUNT) ? 8'h00 : credit_ff + credit_add - credit_sub;
            gap_ff <= slot ? SLOT_GAP : ((gap_ff != '0) ? gap_ff - 4'h1 : gap_ff);
        end
    end
    // lock puts the TS1 byte right after the V5 row's overhead and stuff
    always_ff @(posedge sys_clk) begin
        if (reset || hunt_lock) begin
            spos_ff <= POS_POH;
            srow_ff <= '0;
        end else if (slot) begin
            spos_ff <= s_last ? POS_POH : spos_ff + 6'h01;
            if (s_last) srow_ff <= (srow_ff == ROWS_LAST) ? 2'h0 : srow_ff + 2'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            container_data <= '0;
            container_clock <= 1'b0;
            container_frame_start <= 1'b0;
        end else if (slot && src_function_active) begin
            container_data <= slot_byte;
            container_clock <= ~container_clock;
            container_frame_start <= s_v5;
        end
    end

    // ---------------- sink: container framing ----------------
    logic [5:0] rpos_ff;
    logic [1:0] rrow_ff;
    logic rsync_ff;
    wire r_fs = rfs_s_ff[2];
    wire [5:0] pos_now = r_fs ? POS_POH : rpos_ff;
    wire r_v5 = rx_evt && r_fs;
    wire r_payload = rsync_ff && (pos_now >= POS_FIRST_TS) && (pos_now <= POS_LAST_TS);
    wire snk_wr = rx_evt && r_payload && snk_function_active;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rpos_ff <= '0;
            rrow_ff <= '0;
            rsync_ff <= 1'b0;
        end else if (rx_evt) begin
            rsync_ff <= rsync_ff || r_fs;
            rpos_ff <= (pos_now == ROW_BYTES - 6'h01) ? POS_POH : pos_now + 6'h01;
            if (r_fs) rrow_ff <= '0;
            else if (rpos_ff == ROW_BYTES - 6'h01) rrow_ff <= rrow_ff + 2'h1;
        end
    end

    // ---------------- sink: label acceptance ----------------
    logic [2:0] lab_cand_ff;
    logic [2:0] lab_cnt_ff;
    logic [2:0] acc_lab_ff;
    wire [2:0] rx_label = rd3_ff[LABEL_MSB:LABEL_LSB];
    wire lab_same = (rx_label == lab_cand_ff);
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lab_cand_ff <= '0;
            lab_cnt_ff <= '0;
            acc_lab_ff <= LABEL_BYTE_SYNC;
        end else if (r_v5) begin
            lab_cand_ff <= rx_label;
            lab_cnt_ff <= !lab_same ? 3'h1 : ((lab_cnt_ff != LABEL_PERSIST) ? lab_cnt_ff + 3'h1 : lab_cnt_ff);
            if (lab_same && lab_cnt_ff == LABEL_PERSIST - 3'h1) acc_lab_ff <= rx_label;
        end
    end
    wire plm = (acc_lab_ff != LABEL_BYTE_SYNC);
    wire ais = tsf_lvl_ff || plm;

    // ---------------- sink: elastic store ----------------
    logic snk_in_ready;
    logic snk_out_valid;
    logic [8:0] snk_head;
    logic tick;
    logic started_ff;
    vc12_fifo #(.WIDTH(9), .DEPTH(SNK_DEPTH)) u_snk_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(snk_wr),
        .in_ready(snk_in_ready),
        .in_data({pos_now == POS_FIRST_TS, rd3_ff}),
        .out_valid(snk_out_valid),
        .out_ready(tick && started_ff),
        .out_data(snk_head)
    );
    // reading waits for a half-full store, then runs from the local tick only
    wire snk_ovf = snk_wr && !snk_in_ready;
    always_ff @(posedge sys_clk) begin
        if (reset || snk_ovf || (tick && !snk_out_valid)) begin
            started_ff <= 1'b0;
        end else if (!snk_in_ready || snk_wr && !snk_out_valid && SNK_DEPTH < 3) begin
            started_ff <= 1'b1;
        end else if (snk_out_valid && snk_wr) begin
            started_ff <= 1'b1;
        end
    end

    // ---------------- sink: even output timing ----------------
    logic [15:0] acc_ff;
    wire [15:0] acc_sum = acc_ff + TRIB_BYTE_KHZ_W;
    assign tick = (acc_sum >= SYS_CLK_KHZ_W);
    logic [4:0] ts_ff;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            acc_ff <= '0;
        end else begin
            acc_ff <= tick ? acc_sum - SYS_CLK_KHZ_W : acc_sum;
        end
    end
    wire head_ok = started_ff && snk_out_valid;
    wire out_fs = head_ok ? snk_head[8] : (ts_ff == TS_LAST);
    wire out_ones = ais || !snk_function_active || !head_ok;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ts_ff <= '0;
            tributary_out_data <= ALL_ONES;
            tributary_out_clock <= 1'b0;
            tributary_out_frame_start <= 1'b0;
        end else if (tick) begin
            ts_ff <= out_fs ? 5'h0 : ((ts_ff == TS_LAST) ? 5'h0 : ts_ff + 5'h1);
            tributary_out_data <= out_ones ? ALL_ONES : snk_head[7:0];
            tributary_out_clock <= ~tributary_out_clock;
            tributary_out_frame_start <= out_fs;
        end
    end

    // ---------------- sink: management ----------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            signal_fail_action <= 1'b0;
            label_mismatch_report <= 1'b0;
            accepted_label <= '0;
        end else begin
            signal_fail_action <= ais && snk_function_active;
            label_mismatch_report <= plm && !tsf_lvl_ff && snk_function_active;
            accepted_label <= snk_function_active ? acc_lab_ff : 3'h0;
        end
    end
endmodule // vc12_byte_sync_adapt

// ### vc12_adapt_chk.sv
// concurrent checks on the ports of the vc-12 adaptation block
`timescale 1ns/1ps
module vc12_adapt_chk
    import vc12_adapt_pkg::*;
#(
    parameter int SRC_DEPTH = 4,
    parameter int SNK_DEPTH = 4
) (
    input wire logic sys_clk, // clock
    input wire logic reset, // reset
    input wire logic src_function_active, // source on
    input wire logic [7:0] container_data, // byte
    input wire logic container_clock, // slot toggle
    input wire logic container_frame_start, // v5 marker
    input wire logic trail_signal_fail_in, // trail fail
    input wire logic snk_function_active, // sink on
    input wire logic [7:0] tributary_out_data, // byte
    input wire logic tributary_out_clock, // tick toggle
    input wire logic signal_fail_action, // fail out
    input wire logic label_mismatch_report, // report
    input wire logic [2:0] accepted_label // label
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    sequence s_slot;
        $changed(container_clock);
    endsequence
    sequence s_tsf_held;
        (snk_function_active && trail_signal_fail_in)[*8];
    endsequence
    AST_SLOT_GAP: assert property (s_slot |=> $stable(container_clock)[*8])
        else $error("container slots too close");
    AST_V5_LABEL: assert property ($changed(container_clock) && container_frame_start
        |-> container_data[LABEL_MSB:LABEL_LSB] == LABEL_BYTE_SYNC)
        else $error("wrong label in v5");
    AST_SRC_IDLE: assert property ((!src_function_active)[*3]
        |-> $stable(container_clock) && $stable(container_frame_start))
        else $error("inactive source moved the container port");
    AST_SNK_QUIET: assert property ((!snk_function_active)[*3]
        |-> !label_mismatch_report && !signal_fail_action && accepted_label == 3'h0)
        else $error("inactive sink reports status");
    AST_SNK_ONES: assert property ($fell(snk_function_active) |-> ##[1:300] tributary_out_data == ALL_ONES)
        else $error("inactive sink not all-ones");
    AST_TSF_FAIL: assert property (s_tsf_held |-> signal_fail_action)
        else $error("trail fail without signal fail");
    AST_REPORT_NO_TSF: assert property (trail_signal_fail_in[*8] |-> !label_mismatch_report)
        else $error("mismatch reported under trail fail");
    AST_REPORT_SF: assert property (label_mismatch_report |-> signal_fail_action)
        else $error("mismatch without signal fail");
    AST_MISMATCH: assert property ((snk_function_active && !trail_signal_fail_in
        && accepted_label != LABEL_BYTE_SYNC && accepted_label != 3'h0)[*6] |-> label_mismatch_report)
        else $error("foreign label not reported");
    AST_OUT_GAP: assert property ($changed(tributary_out_clock) |=> $stable(tributary_out_clock)[*8])
        else $error("output ticks too close");
    AST_OUT_ONES: assert property (s_tsf_held ##0 $changed(tributary_out_clock)
        |-> tributary_out_data == ALL_ONES)
        else $error("payload passed under trail fail");
endmodule // vc12_adapt_chk

// ### vc12_far_end.sv
// far-end path termination model: loops the container back, may send a foreign label
`timescale 1ns/1ps
module vc12_far_end (
    input wire logic sys_clk, // clock
    input wire logic [7:0] tx_data, // container byte
    input wire logic tx_clock, // slot toggle
    input wire logic tx_frame_start, // v5 marker
    input wire logic bad_label, // corrupt v5 label
    output logic [7:0] rx_data, // looped byte
    output logic rx_clock, // looped toggle
    output logic rx_frame_start // looped marker
);
    // label 010 is foreign to the byte-synchronous mapping
    wire logic [7:0] nxt_data = (tx_frame_start && bad_label) ? {tx_data[7:4], 3'h2, tx_data[0]} : tx_data;
    always_ff @(posedge sys_clk) begin
        rx_data <= nxt_data;
        rx_clock <= tx_clock;
        rx_frame_start <= tx_frame_start;
    end
endmodule // vc12_far_end

// ### vc12_byte_sync_1984k_adaptation_bench.sv
// testbench: source mapping, server fail, sink recovery, label mismatch, activation
`timescale 1ns/1ps
module vc12_byte_sync_1984k_adaptation_bench;
    import vc12_adapt_pkg::*;
    // one container frame carries four tributary frames of 31 bytes each
    localparam int FRAME_CYC = 25050;
    localparam int ROW_CYC = 6260;
    logic sys_clk = 1'b0;
    logic tributary_clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] tributary_data = 8'h00;
    logic tributary_byte_valid = 1'b0;
    logic tributary_frame_start = 1'b0;
    logic server_fail_in = 1'b0;
    logic src_function_active = 1'b1;
    logic trail_signal_fail_in = 1'b0;
    logic snk_function_active = 1'b1;
    logic bad_label = 1'b0;
    logic [7:0] container_data, rx_container_data, tributary_out_data;
    logic container_clock, container_frame_start, rx_container_clock, rx_container_frame_start;
    logic tributary_out_clock, tributary_out_frame_start, signal_fail_action, label_mismatch_report;
    logic [2:0] accepted_label;
    logic [7:0] cap [0:139];
    logic cc_q = 1'b0;
    logic oc_q = 1'b0;
    int pos = 0;
    int frame_len = 0;
    int sk_pos = 0;
    int good = 0;
    int n_mismatch = 0;
    int check_count = 0;
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #3.3;
        forever #7.5 tributary_clock = ~tributary_clock;
    end
    vc12_byte_sync_adapt i_dut (.sys_clk(sys_clk), .reset(reset), .tributary_clock(tributary_clock),
        .tributary_data(tributary_data), .tributary_byte_valid(tributary_byte_valid),
        .tributary_frame_start(tributary_frame_start), .server_fail_in(server_fail_in),
        .src_function_active(src_function_active), .container_data(container_data),
        .container_clock(container_clock), .container_frame_start(container_frame_start),
        .rx_container_data(rx_container_data), .rx_container_clock(rx_container_clock),
        .rx_container_frame_start(rx_container_frame_start), .trail_signal_fail_in(trail_signal_fail_in),
        .snk_function_active(snk_function_active), .tributary_out_data(tributary_out_data),
        .tributary_out_clock(tributary_out_clock), .tributary_out_frame_start(tributary_out_frame_start),
        .signal_fail_action(signal_fail_action), .label_mismatch_report(label_mismatch_report),
        .accepted_label(accepted_label));
    vc12_far_end i_far (.sys_clk(sys_clk), .tx_data(container_data), .tx_clock(container_clock),
        .tx_frame_start(container_frame_start), .bad_label(bad_label), .rx_data(rx_container_data),
        .rx_clock(rx_container_clock), .rx_frame_start(rx_container_frame_start));
    // one tributary byte every 269 link clocks, close to the sink's even read rate
    initial begin
        int ts;
        ts = 0;
        wait (reset === 1'b0);
        forever begin
            repeat (268) @(posedge tributary_clock);
            #1;
            tributary_data = 8'h40 + 8'(ts);
            tributary_frame_start = (ts == 0);
            tributary_byte_valid = 1'b1;
            @(posedge tributary_clock);
            #1;
            tributary_byte_valid = 1'b0;
            ts = (ts == 30) ? 0 : ts + 1;
        end
    end
    always @(posedge sys_clk) begin
        cc_q <= container_clock;
        oc_q <= tributary_out_clock;
        if (container_clock !== cc_q) begin
            if (container_frame_start === 1'b1) begin
                frame_len = pos + 1;
                pos = 0;
            end else begin
                pos = pos + 1;
            end
            if (pos < 140) cap[pos] = container_data;
        end
        if (tributary_out_clock !== oc_q) begin
            sk_pos = (tributary_out_frame_start === 1'b1) ? 0 : sk_pos + 1;
            if (tributary_out_data === 8'h40 + sk_pos[7:0]) good = good + 1;
        end
    end
    task automatic check(input logic ok, input string what);
        check_count = check_count + 1;
        if (!ok) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic src_checks(input logic fail);
        logic ok;
        ok = 1'b1;
        for (int k = 0; k < 31; k++) begin
            ok = ok && (cap[k + 2] === (fail ? ALL_ONES : 8'h40 + 8'(k)));
        end
        check(frame_len == 140, "container frame length");
        check(cap[0][3:1] === LABEL_BYTE_SYNC, "v5 label");
        check(ok, "timeslot bytes");
    endtask
    task automatic t_source_map();
        repeat (2 * FRAME_CYC) @(posedge sys_clk);
        src_checks(1'b0);
        $display("test source_map done");
    endtask
    task automatic t_server_fail();
        #1 server_fail_in = 1'b1;
        repeat (FRAME_CYC + ROW_CYC) @(posedge sys_clk);
        src_checks(1'b1);
        #1 server_fail_in = 1'b0;
        repeat (FRAME_CYC + ROW_CYC) @(posedge sys_clk);
        src_checks(1'b0);
        $display("test server_fail done");
    endtask
    task automatic t_sink_ok();
        repeat (ROW_CYC) @(posedge sys_clk);
        good = 0;
        repeat (ROW_CYC) @(posedge sys_clk);
        check(good >= 20, "sink payload or frame phase");
        check(accepted_label === LABEL_BYTE_SYNC, "accepted label");
        check(label_mismatch_report === 1'b0 && signal_fail_action === 1'b0, "false alarm");
        $display("test sink_ok done");
    endtask
    task automatic t_mismatch();
        #1 bad_label = 1'b1;
        repeat (5 * FRAME_CYC) @(posedge sys_clk);
        good = 0;
        repeat (ROW_CYC) @(posedge sys_clk);
        check(accepted_label === 3'h2, "foreign label not accepted");
        check(label_mismatch_report === 1'b1 && signal_fail_action === 1'b1, "no mismatch");
        check(good == 0, "payload passed on mismatch");
        #1 trail_signal_fail_in = 1'b1;
        repeat (20) @(posedge sys_clk);
        check(label_mismatch_report === 1'b0 && signal_fail_action === 1'b1, "report under trail fail");
        #1 trail_signal_fail_in = 1'b0;
        bad_label = 1'b0;
        $display("test mismatch done");
    endtask
    task automatic t_inactive();
        logic cc;
        #1 snk_function_active = 1'b0;
        src_function_active = 1'b0;
        repeat (400) @(posedge sys_clk);
        cc = container_clock;
        check(accepted_label === 3'h0 && signal_fail_action === 1'b0, "inactive sink status");
        check(tributary_out_data === ALL_ONES, "inactive sink data");
        repeat (400) @(posedge sys_clk);
        check(container_clock === cc, "inactive source moved");
        $display("test inactive done");
    endtask
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        // label acceptance alone needs five container frames, so the run is long
        #6_000_000;
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        #1 reset = 1'b0;
        t_source_map();
        t_server_fail();
        t_sink_ok();
        t_mismatch();
        t_inactive();
        end_of_test();
    end
endmodule // vc12_byte_sync_1984k_adaptation_bench
bind vc12_byte_sync_adapt vc12_adapt_chk #(.SRC_DEPTH(SRC_DEPTH), .SNK_DEPTH(SNK_DEPTH)) i_chk (
    .sys_clk(sys_clk), .reset(reset), .src_function_active(src_function_active),
    .container_data(container_data), .container_clock(container_clock),
    .container_frame_start(container_frame_start), .trail_signal_fail_in(trail_signal_fail_in),
    .snk_function_active(snk_function_active), .tributary_out_data(tributary_out_data),
    .tributary_out_clock(tributary_out_clock), .signal_fail_action(signal_fail_action),
    .label_mismatch_report(label_mismatch_report), .accepted_label(accepted_label));
